// ==== hdl/usb_device_command_port.sv ====
// Notes on behaviour
// - Each command is a command access then zero or more data accesses.
// - 0xD0 write: bits 6..0 address, bit 7 enable; both reset to zero.
// - A written address only takes effect once the host's status phase completes.
// - Bus reset clears address, sets enable, answers address zero.
// - 0xD8 write bit 0 enables non-control endpoints; reset disabled.
// - 0xF3 mode bit: 1 reports NAKs as interrupts; default 0.
// - 0xF4 reads interrupt sources; endpoint bits clear only by 0x40.. reads.
// - 0xF5 reads 11-bit frame number, low byte first, one or two bytes.
// - Missed SOF keeps old frame; CRC-bad SOF number stored as received.
// - 0xFD reads fixed 16-bit identity, low byte first.
// - 0xFE read returns device status; write only requests wakeup (bit 2 = 0 while suspended).
// - 0xFF reads error code in bits 3..0, bit 4 error flag.
// - Codes 0x00..0x05 select one physical endpoint; optional status read.
// - Select sets buffer pointer to that endpoint's buffer start.
// - Status bit 2 suspend, bits 3,4 change flags cleared on read.
// - Interrupt bit 7 device event clears on device status read.
`timescale 1ns/10ps
`default_nettype none
module usb_device_command_port
  import usb_cmd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire mc_access_t  mc,
  input  wire sie_event_t  sie,
  input  wire logic [7:0]  buf_rdata,
  output var  logic [7:0]  rdata_ff,
  output var  logic [6:0]  func_address_ff,
  output var  logic        func_enable_ff,
  output var  logic        ep_enable_ff,
  output var  logic        nak_report_ff,
  output var  logic [2:0]  selected_ep_ff,
  output var  logic [6:0]  buf_ptr_ff,
  output var  logic        buf_write_ff,
  output var  logic [7:0]  buf_wdata_ff,
  output var  logic        buf_clear_ff,
  output var  logic        buf_validate_ff,
  output var  logic        ep_status_wr_ff,
  output var  logic [7:0]  ep_status_ff,
  output var  logic        remote_wakeup_ff,
  output var  logic        int_ff
);

  logic [7:0]  command_ff;
  logic        byte_idx_ff;
  logic [7:0]  int_src_ff;
  logic [10:0] frame_ff;
  logic [7:0]  dev_stat_ff;
  logic [3:0]  err_code_ff;
  logic        err_flag_ff;
  logic [6:0]  addr_w;
  logic        en_w;

  function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction : in_range

  wire logic cmd_take  = mc.sel && mc.cmd && mc.wr;
  wire logic data_wr   = mc.sel && !mc.cmd && mc.wr;
  wire logic data_rd   = mc.sel && !mc.cmd && mc.rd;
  wire logic is_sel    = in_range(command_ff, cmd_select_ep_first, cmd_select_ep_last);
  wire logic is_clrint = in_range(command_ff, cmd_clr_int_first, cmd_clr_int_last);
  wire logic [2:0] cmd_ep = command_ff[2:0] & ep_idx_mask;
  wire logic [2:0] new_ep = mc.wdata[2:0] & ep_idx_mask;
  wire logic stat_rd   = data_rd && (command_ff == cmd_device_status);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      command_ff  <= 8'h00;
      byte_idx_ff <= 1'b0;
    end else if (cmd_take) begin
      command_ff  <= mc.wdata;
      byte_idx_ff <= 1'b0;
    end else if (data_rd || data_wr) begin
      byte_idx_ff <= 1'b1;
    end
  end

  usb_addr_holder u_addr (
    .clk        (clk),
    .reset      (reset),
    .wr_en      (data_wr && (command_ff == cmd_set_address)),
    .wdata      (mc.wdata),
    .status_ok  (sie.addr_status_ok),
    .bus_reset  (sie.bus_reset),
    .address_ff (addr_w),
    .enable_ff  (en_w)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      func_address_ff <= 7'h00;
      func_enable_ff  <= 1'b0;
    end else begin
      func_address_ff <= addr_w;
      func_enable_ff  <= en_w;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ep_enable_ff  <= 1'b0;
      nak_report_ff <= 1'b0;
    end else if (data_wr && (command_ff == cmd_set_ep_enable)) begin
      ep_enable_ff  <= mc.wdata[0];
    end else if (data_wr && (command_ff == cmd_set_mode)) begin
      nak_report_ff <= mc.wdata[0];
    end
  end

  // A write steps the pointer only once its strobe has carried the old address out
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      selected_ep_ff <= 3'h0;
      buf_ptr_ff     <= 7'h00;
    end else if (cmd_take && in_range(mc.wdata, cmd_select_ep_first, cmd_select_ep_last)) begin
      selected_ep_ff <= new_ep;
      buf_ptr_ff     <= ep_buf_start[new_ep];
    end else if (cmd_take && in_range(mc.wdata, cmd_clr_int_first, cmd_clr_int_last)) begin
      selected_ep_ff <= new_ep;
      buf_ptr_ff     <= ep_buf_start[new_ep];
    end else if ((data_rd && (command_ff == cmd_buffer_rw)) || buf_write_ff) begin
      buf_ptr_ff     <= buf_ptr_ff + 7'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      buf_write_ff    <= 1'b0;
      buf_wdata_ff    <= 8'h00;
      buf_clear_ff    <= 1'b0;
      buf_validate_ff <= 1'b0;
      ep_status_wr_ff <= 1'b0;
      ep_status_ff    <= 8'h00;
    end else begin
      buf_write_ff    <= data_wr && (command_ff == cmd_buffer_rw);
      buf_wdata_ff    <= mc.wdata;
      buf_clear_ff    <= cmd_take && (mc.wdata == cmd_clear_buffer);
      buf_validate_ff <= cmd_take && (mc.wdata == cmd_validate_buffer);
      ep_status_wr_ff <= data_wr && is_clrint;
      if (data_wr && is_clrint) begin
        ep_status_ff <= mc.wdata;
      end
    end
  end

  // Interrupt sources: new events win over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_src_ff <= 8'h00;
    end else begin
      for (int i = 0; i < num_eps; i++) begin
        if (sie.ep_event[i] && (ep_enable_ff || i < 2) && !(sie.nak_event && !nak_report_ff)) begin
          int_src_ff[i] <= 1'b1;
        end else if (data_rd && is_clrint && (cmd_ep == i[2:0])) begin
          int_src_ff[i] <= 1'b0;
        end
      end
      if (sie.bus_reset || (sie.suspend != dev_stat_ff[stat_suspend_bit])) begin
        int_src_ff[int_device_event_bit] <= 1'b1;
      end else if (stat_rd) begin
        int_src_ff[int_device_event_bit] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_ff <= 11'h000;
    end else if (sie.sof_valid) begin
      frame_ff <= sie.sof_frame;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dev_stat_ff      <= 8'h00;
      remote_wakeup_ff <= 1'b0;
    end else begin
      dev_stat_ff[stat_suspend_bit] <= sie.suspend;
      if (sie.suspend != dev_stat_ff[stat_suspend_bit]) begin
        dev_stat_ff[stat_susp_change_bit] <= 1'b1;
      end else if (stat_rd) begin
        dev_stat_ff[stat_susp_change_bit] <= 1'b0;
      end
      if (sie.bus_reset) begin
        dev_stat_ff[stat_bus_reset_bit] <= 1'b1;
      end else if (stat_rd) begin
        dev_stat_ff[stat_bus_reset_bit] <= 1'b0;
      end
      // Writing bit 2 as 0 while suspended requests a wakeup; other writes do nothing
      remote_wakeup_ff <= data_wr && (command_ff == cmd_device_status) &&
                          dev_stat_ff[stat_suspend_bit] && !mc.wdata[stat_suspend_bit];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_code_ff <= 4'h0;
      err_flag_ff <= 1'b0;
    end else if (sie.error_valid) begin
      err_code_ff <= sie.error_code;
      err_flag_ff <= 1'b1;
    end else if (sie.transfer_start) begin
      err_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (data_rd) begin
      if (command_ff == cmd_read_int) begin
        rdata_ff <= int_src_ff;
      end else if (command_ff == cmd_read_frame) begin
        rdata_ff <= byte_idx_ff ? {5'h00, frame_ff[10:8]} : frame_ff[7:0];
      end else if (command_ff == cmd_read_chip_id) begin
        rdata_ff <= byte_idx_ff ? chip_id_value[15:8] : chip_id_value[7:0];
      end else if (command_ff == cmd_device_status) begin
        rdata_ff <= dev_stat_ff;
      end else if (command_ff == cmd_error_code) begin
        rdata_ff <= {3'h0, err_flag_ff, err_code_ff};
      end else if (command_ff == cmd_buffer_rw || command_ff == cmd_clear_buffer) begin
        rdata_ff <= buf_rdata;
      end else if (is_sel || is_clrint) begin
        rdata_ff <= {7'h00, int_src_ff[cmd_ep]};
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_ff <= 1'b0;
    end else begin
      int_ff <= |int_src_ff;
    end
  end

endmodule : usb_device_command_port
`default_nettype wire

// ==== pkg/usb_cmd_pkg.sv ====
package usb_cmd_pkg;

  localparam logic [7:0] cmd_set_address      = 8'hd0;
  localparam logic [7:0] cmd_set_ep_enable    = 8'hd8;
  localparam logic [7:0] cmd_set_mode         = 8'hf3;
  localparam logic [7:0] cmd_read_int         = 8'hf4;
  localparam logic [7:0] cmd_read_frame       = 8'hf5;
  localparam logic [7:0] cmd_read_chip_id     = 8'hfd;
  localparam logic [7:0] cmd_device_status    = 8'hfe;
  localparam logic [7:0] cmd_error_code       = 8'hff;
  localparam logic [7:0] cmd_buffer_rw        = 8'hf0;
  localparam logic [7:0] cmd_clear_buffer     = 8'hf2;
  localparam logic [7:0] cmd_validate_buffer  = 8'hfa;
  localparam logic [7:0] cmd_select_ep_first  = 8'h00;
  localparam logic [7:0] cmd_select_ep_last   = 8'h05;
  localparam logic [7:0] cmd_clr_int_first    = 8'h40;
  localparam logic [7:0] cmd_clr_int_last     = 8'h45;

  localparam int         num_eps              = 6;
  localparam logic [2:0] ep_idx_mask          = 3'h7;

  // Chip identity; value is arbitrary
  localparam logic [15:0] chip_id_value       = 16'h5a31;

  // Bit positions
  localparam int addr_enable_bit              = 7;
  localparam int stat_suspend_bit             = 2;
  localparam int stat_susp_change_bit         = 3;
  localparam int stat_bus_reset_bit           = 4;
  localparam int int_device_event_bit         = 7;
  localparam int err_occurred_bit             = 4;

  // Buffer start pointers per physical endpoint (packed buffer layout)
  localparam logic [6:0] ep_buf_start [num_eps] = '{7'h00, 7'h10, 7'h20, 7'h40, 7'h60, 7'h68};

  typedef struct packed {
    logic       sel;
    logic       cmd;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mc_access_t;

  typedef struct packed {
    logic        sof_valid;
    logic [10:0] sof_frame;
    logic        bus_reset;
    logic        suspend;
    logic        addr_status_ok;
    logic [5:0]  ep_event;
    logic        nak_event;
    logic        error_valid;
    logic [3:0]  error_code;
    logic        transfer_start;
  } sie_event_t;

endpackage : usb_cmd_pkg

// ==== hdl/usb_addr_holder.sv ====
`timescale 1ns/10ps
`default_nettype none
// Holds the function address; a written value stays pending until the
// host's address transaction completes its status phase.
module usb_addr_holder
  import usb_cmd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] wdata,
  input  wire logic       status_ok,
  input  wire logic       bus_reset,
  output var  logic [6:0] address_ff,
  output var  logic       enable_ff
);

  logic [7:0] pending_ff;
  logic       pending_valid_ff;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending_ff       <= 8'h00;
      pending_valid_ff <= 1'b0;
    end else if (bus_reset) begin
      pending_valid_ff <= 1'b0;
    end else if (wr_en) begin
      pending_ff       <= wdata;
      pending_valid_ff <= 1'b1;
    end else if (status_ok) begin
      pending_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      address_ff <= 7'h00;
      enable_ff  <= 1'b0;
    end else if (bus_reset) begin
      address_ff <= 7'h00;
      enable_ff  <= 1'b1;
    end else if (status_ok && pending_valid_ff && !wr_en) begin
      // Failed status phase never reaches here, so the old address stays
      address_ff <= pending_ff[6:0];
      enable_ff  <= pending_ff[addr_enable_bit];
    end
  end

endmodule : usb_addr_holder
`default_nettype wire

// ==== verif/usb_cmd_port_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_cmd_port_checker
  import usb_cmd_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire mc_access_t mc,
  input wire sie_event_t sie,
  input wire logic [7:0] rdata_ff,
  input wire logic [6:0] func_address_ff,
  input wire logic       func_enable_ff,
  input wire logic       ep_enable_ff,
  input wire logic       nak_report_ff,
  input wire logic [2:0] selected_ep_ff,
  input wire logic [6:0] buf_ptr_ff,
  input wire logic       buf_write_ff,
  input wire logic [7:0] buf_wdata_ff,
  input wire logic       buf_validate_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_hold: assert property (!$past(mc.sel && mc.rd) |-> $stable(rdata_ff))
    else $error("read byte moved without a read");
  a_addr_hold: assert property ((!sie.addr_status_ok && !sie.bus_reset)[*3] |=> $stable(func_address_ff))
    else $error("address moved without status phase");
  a_bus_reset_addr: assert property (sie.bus_reset |-> ##[1:3] (func_address_ff == 7'h00 && func_enable_ff))
    else $error("bus reset left address or enable wrong");
  a_ep_enable_set: assert property ((mc.sel && mc.cmd && mc.wr && mc.wdata == cmd_set_ep_enable) ##1
    (mc.sel && !mc.cmd && mc.wr && mc.wdata[0]) |-> ##[1:2] ep_enable_ff)
    else $error("endpoint enable not set");
  a_nak_mode_set: assert property ((mc.sel && mc.cmd && mc.wr && mc.wdata == cmd_set_mode) ##1
    (mc.sel && !mc.cmd && mc.wr && mc.wdata[0]) |-> ##[1:2] nak_report_ff)
    else $error("nak mode not set");
  a_chip_low: assert property ((mc.sel && mc.cmd && mc.wr && mc.wdata == cmd_read_chip_id) ##1
    (mc.sel && !mc.cmd && mc.rd) |=> rdata_ff == chip_id_value[7:0])
    else $error("identity low byte wrong");
  a_select_ptr: assert property ($changed(selected_ep_ff) |-> buf_ptr_ff == ep_buf_start[selected_ep_ff])
    else $error("pointer not at buffer start");
  a_buf_write: assert property (buf_write_ff |-> $past(mc.sel && mc.wr && !mc.cmd)
    && buf_wdata_ff == $past(mc.wdata))
    else $error("buffer write without data access");
  a_validate: assert property (buf_validate_ff |-> $past(mc.sel && mc.cmd && mc.wr
    && mc.wdata == cmd_validate_buffer))
    else $error("validate pulse without command");
endmodule : usb_cmd_port_checker
bind usb_device_command_port usb_cmd_port_checker u_chk (.clk, .reset, .mc, .sie, .rdata_ff, .func_address_ff,
  .func_enable_ff, .ep_enable_ff, .nak_report_ff, .selected_ep_ff, .buf_ptr_ff, .buf_write_ff, .buf_wdata_ff,
  .buf_validate_ff);
`default_nettype wire

// ==== verif/usb_buf_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_buf_model
  import usb_cmd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [6:0] buf_ptr_ff,
  input  wire logic       buf_write_ff,
  input  wire logic [7:0] buf_wdata_ff,
  output var  logic [7:0] buf_rdata
);
  logic [7:0] mem [128];
  // Preset with a pattern so an unwritten byte never reads as zero
  initial for (int i = 0; i < 128; i++) mem[i] = ~8'(i);
  always @(posedge clk) if (buf_write_ff) mem[buf_ptr_ff] <= buf_wdata_ff;
  assign buf_rdata = mem[buf_ptr_ff];
endmodule : usb_buf_model
`default_nettype wire

// ==== verif/usb_device_command_port_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module usb_device_command_port_bench
  import usb_cmd_pkg::*;
();
  logic clk = 0, reset = 1;
  mc_access_t mc = '0;
  sie_event_t sie = '0, s;
  logic [7:0] buf_rdata, rdata_ff, buf_wdata_ff, ep_status_ff;
  logic [6:0] func_address_ff, buf_ptr_ff;
  logic [2:0] selected_ep_ff;
  logic func_enable_ff, ep_enable_ff, nak_report_ff, buf_write_ff, buf_clear_ff;
  logic buf_validate_ff, ep_status_wr_ff, remote_wakeup_ff, int_ff;
  int n_mismatch = 0, compares = 0;
  always #2.5 clk = ~clk;
  usb_device_command_port DUT (.clk, .reset, .mc, .sie, .buf_rdata, .rdata_ff, .func_address_ff, .func_enable_ff,
    .ep_enable_ff, .nak_report_ff, .selected_ep_ff, .buf_ptr_ff, .buf_write_ff, .buf_wdata_ff, .buf_clear_ff,
    .buf_validate_ff, .ep_status_wr_ff, .ep_status_ff, .remote_wakeup_ff, .int_ff);
  usb_buf_model u_buf (.clk, .buf_ptr_ff, .buf_write_ff, .buf_wdata_ff, .buf_rdata);
  task automatic chk(logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic acc(logic c, w, logic [7:0] d);
    mc = '{sel: 1'b1, cmd: c, wr: w, rd: !w, wdata: d};
    @(negedge clk);
  endtask : acc
  task automatic idle(int n = 1);
    mc = '0;
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic pulse(sie_event_t p);
    sie = sie_event_t'(sie | p);
    @(negedge clk);
    sie = sie_event_t'(sie & ~p);
  endtask : pulse
  task automatic rd(logic [7:0] e);
    acc(1'b0, 1'b0, 8'h00);
    chk(rdata_ff, e);
  endtask : rd
  task automatic cmd_rd(logic [7:0] c, e);
    acc(1'b1, 1'b1, c);
    rd(e);
    idle();
  endtask : cmd_rd
  task automatic t_power_on();
    chk({func_enable_ff, func_address_ff}, 8'h00);
    chk(8'(ep_enable_ff), 8'h00);
    chk(8'(nak_report_ff), 8'h00);
    cmd_rd(cmd_read_int, 8'h00);
    cmd_rd(cmd_error_code, 8'h00);
  endtask : t_power_on
  task automatic t_address();
    acc(1'b1, 1'b1, cmd_set_address);
    acc(1'b0, 1'b1, 8'h85);
    idle(4);
    chk({func_enable_ff, func_address_ff}, 8'h00);
    s = '0;
    s.addr_status_ok = 1'b1;
    pulse(s);
    idle(3);
    chk({func_enable_ff, func_address_ff}, 8'h85);
    s = '0;
    s.bus_reset = 1'b1;
    pulse(s);
    idle(3);
    chk({func_enable_ff, func_address_ff}, 8'h80);
  endtask : t_address
  task automatic t_status();
    sie.suspend = 1'b1;
    idle(2);
    cmd_rd(cmd_read_int, 8'h80);
    cmd_rd(cmd_device_status, 8'h1c);
    cmd_rd(cmd_device_status, 8'h04);
    cmd_rd(cmd_read_int, 8'h00);
    acc(1'b1, 1'b1, cmd_device_status);
    acc(1'b0, 1'b1, 8'h00);
    chk(8'(remote_wakeup_ff), 8'h01);
    idle();
  endtask : t_status
  task automatic t_modes_and_reads();
    acc(1'b1, 1'b1, cmd_set_ep_enable);
    acc(1'b0, 1'b1, 8'h01);
    acc(1'b1, 1'b1, cmd_set_mode);
    acc(1'b0, 1'b1, 8'h01);
    idle(2);
    chk({6'h00, ep_enable_ff, nak_report_ff}, 8'h03);
    s = '0;
    s.sof_valid = 1'b1;
    s.sof_frame = 11'h5a3;
    pulse(s);
    acc(1'b1, 1'b1, cmd_read_frame);
    rd(8'ha3);
    rd(8'h05);
    acc(1'b1, 1'b1, cmd_read_chip_id);
    rd(chip_id_value[7:0]);
    rd(chip_id_value[15:8]);
    acc(1'b1, 1'b1, cmd_read_frame);
    rd(8'ha3);
    idle();
    s = '0;
    s.error_valid = 1'b1;
    s.error_code = 4'h5;
    pulse(s);
    cmd_rd(cmd_error_code, 8'h15);
  endtask : t_modes_and_reads
  task automatic t_endpoint();
    acc(1'b1, 1'b1, 8'h03);
    idle();
    chk({selected_ep_ff, 5'h00}, 8'h60);
    chk(8'(buf_ptr_ff), 8'h40);
    s = '0;
    s.ep_event = 6'h08;
    pulse(s);
    idle(2);
    chk(8'(int_ff), 8'h01);
    cmd_rd(cmd_read_int, 8'h08);
    cmd_rd(cmd_read_int, 8'h08);
    acc(1'b1, 1'b1, 8'h43);
    rd(8'h01);
    idle();
    cmd_rd(cmd_read_int, 8'h00);
    acc(1'b1, 1'b1, 8'h43);
    acc(1'b0, 1'b1, 8'h5c);
    chk({ep_status_wr_ff, 7'h00}, 8'h80);
    chk(ep_status_ff, 8'h5c);
    acc(1'b1, 1'b1, cmd_buffer_rw);
    acc(1'b0, 1'b1, 8'haa);
    chk({buf_write_ff, 7'h00}, 8'h80);
    chk(buf_wdata_ff, 8'haa);
    acc(1'b1, 1'b1, cmd_validate_buffer);
    chk(8'(buf_validate_ff), 8'h01);
    acc(1'b1, 1'b1, cmd_clear_buffer);
    chk(8'(buf_clear_ff), 8'h01);
    idle();
  endtask : t_endpoint
  task automatic t_nak_mode();
    s = '0;
    s.ep_event = 6'h10;
    s.nak_event = 1'b1;
    acc(1'b1, 1'b1, cmd_set_mode);
    acc(1'b0, 1'b1, 8'h00);
    idle();
    pulse(s);
    cmd_rd(cmd_read_int, 8'h00);
    acc(1'b1, 1'b1, cmd_set_mode);
    acc(1'b0, 1'b1, 8'h01);
    idle();
    pulse(s);
    cmd_rd(cmd_read_int, 8'h10);
  endtask : t_nak_mode
  // Reads back the byte written at the endpoint's start, then an unwritten preset byte
  task automatic t_buffer();
    acc(1'b1, 1'b1, 8'h03);
    acc(1'b1, 1'b1, cmd_buffer_rw);
    rd(8'haa);
    rd(8'hbe);
    idle();
  endtask : t_buffer
  task automatic print_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    t_power_on();
    t_address();
    t_status();
    t_modes_and_reads();
    t_endpoint();
    t_nak_mode();
    t_buffer();
    print_verdict();
  end
  // A hang counts against the run rather than stalling it
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : usb_device_command_port_bench
`default_nettype wire
